/* rtl/cfg_regs_map.svh */
`ifndef CFG_REGS_MAP_SVH
`define CFG_REGS_MAP_SVH

// Configuration register indices
`define IDX_UART_MODE       8'h0c
`define IDX_DEVICE_ID       8'h0d
`define IDX_REVISION        8'h0e
`define IDX_TEST_ONE        8'h0f
`define IDX_TEST_TWO        8'h10
`define IDX_TEST_THREE      8'h11
`define IDX_BASE_LOW        8'h12
`define IDX_BASE_HIGH       8'h13

// Reset values
`define RST_UART_MODE       8'h02
`define RST_TEST_ONE        8'h00
`define RST_TEST_TWO        8'h00
`define RST_TEST_THREE      8'h80
`define RST_BASE_LOW_STRAP0 8'h2e
`define RST_BASE_LOW_STRAP1 8'h4e
`define RST_BASE_HIGH       8'h00

// Identity codes; values are arbitrary
`define DEVICE_ID_VALUE     8'ha5
`define REVISION_VALUE      8'h01

// Field masks
`define BASE_LOW_MASK       8'hfe
`define BASE_HIGH_MASK      8'h07

`endif

/* rtl/cfg_regs_pkg.sv */
package cfg_regs_pkg;

  typedef enum logic [2:0] {
    MODE_STANDARD = 3'b000,
    MODE_HP_IR    = 3'b001,
    MODE_ASK_IR   = 3'b010
  } port2_mode_t;

  typedef struct packed {
    logic       port2_fast;
    logic       port1_fast;
    logic [2:0] port2_mode;
    logic       port2_half_duplex;
    logic       port2_tx_low;
    logic       port2_rx_low;
  } uart_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } cfg_access_t;

  typedef struct packed {
    logic       port2_rx_invert;
    logic       port2_tx_invert;
    logic       port2_half_duplex;
    logic       port2_std;
    logic       port2_hp_ir;
    logic       port2_ask_ir;
    logic       port2_mode_bad;
    logic       port1_fast;
    logic       port2_fast;
  } uart_ctrl_t;

endpackage

/* rtl/uart_mode_decode.sv */
`include "cfg_regs_map.svh"

module uart_mode_decode (
  // Mode register contents
  input  wire cfg_regs_pkg::uart_mode_t mode_i,
  // Decoded controls
  output wire cfg_regs_pkg::uart_ctrl_t ctrl_o
);

  wire [2:0] mode_code;

  assign mode_code                = mode_i.port2_mode;
  assign ctrl_o.port2_rx_invert   = mode_i.port2_rx_low;
  assign ctrl_o.port2_tx_invert   = mode_i.port2_tx_low;
  assign ctrl_o.port2_half_duplex = mode_i.port2_half_duplex;
  assign ctrl_o.port2_std         = mode_code == cfg_regs_pkg::MODE_STANDARD;
  assign ctrl_o.port2_hp_ir       = mode_code == cfg_regs_pkg::MODE_HP_IR;
  assign ctrl_o.port2_ask_ir      = mode_code == cfg_regs_pkg::MODE_ASK_IR;
  // Reserved codes fall back to none of the three functions
  assign ctrl_o.port2_mode_bad    = mode_code[2] | (mode_code == 3'h3);
  assign ctrl_o.port1_fast        = mode_i.port1_fast;
  assign ctrl_o.port2_fast        = mode_i.port2_fast;

endmodule // uart_mode_decode

/* rtl/cfg_port_decode.sv */
`include "cfg_regs_map.svh"

module cfg_port_decode (
  // Host address
  input  wire logic [15:0] host_addr_i,
  // Active base
  input  wire logic [7:0]  base_low_i,
  input  wire logic [2:0]  base_high_i,
  // Match results
  output wire logic        hit_index_o,
  output wire logic        hit_data_o
);

  wire upper_zero;
  wire pair_match;

  assign upper_zero  = host_addr_i[15:11] == 5'h00;
  assign pair_match  = upper_zero && host_addr_i[10:1] == {base_high_i, base_low_i[7:1]};
  // Even base: index port at A0=0, data port at A0=1
  assign hit_index_o = pair_match && !host_addr_i[0];
  assign hit_data_o  = pair_match && host_addr_i[0];

endmodule // cfg_port_decode

/* rtl/cfg_uart_regs.sv */
`include "cfg_regs_map.svh"

// What this block does
// - Mode register reached only in configuration state with index 0x0c.
// - Mode register returns to 0x02 on power-on or hardware reset.
// - Bit 0 sets port two receive polarity; low is active high.
// - Bit 1 sets port two transmit polarity; default active low.
// - Bit 2 picks half duplex when set, full duplex when clear.
// - Bits 5:3 pick standard, HP infrared or ASK infrared; others reserved.
// - Bit 6 enables port one high speed.
// - Bit 7 enables port two high speed.
// - Identification register is read-only, fixed code, at index 0x0d.
// - Revision register is read-only, fixed code, at index 0x0e.
// - Three test registers at 0x0f-0x11 are plain read/write storage.
// - Test registers reset to 0x00, 0x00 and 0x80.
// - Port decode compares address 10:1 with base; 15:11 must be zero.
// - Base is even; low base bit 0 ignores writes and reads zero.
// - Low base resets to 0x2e with strap low, 0x4e with strap high.
// - After the strap reload, decode moves only when the high base register is written.
// - High base holds address 10:8 in bits 2:0, resets to zero.
module cfg_uart_regs (
  // Clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     nrst_i,
  // Strap and configuration state
  input  wire logic                     base_address_strap_i,
  input  wire logic                     config_active_i,
  // Register access from the index/data mechanism
  input  wire cfg_regs_pkg::cfg_access_t access_i,
  output logic [7:0]                    rdata_o,
  output logic                          rvalid_o,
  // Host address decode
  input  wire logic [15:0]              host_addr_i,
  output wire logic                     hit_index_o,
  output wire logic                     hit_data_o,
  // Serial port controls and test register contents
  output wire cfg_regs_pkg::uart_ctrl_t uart_ctrl_o,
  output logic [7:0]                    test_one_o,
  output logic [7:0]                    test_two_o,
  output logic [7:0]                    test_three_o
);

  cfg_regs_pkg::uart_mode_t uart_mode_control;
  logic [7:0]               config_port_base_low;
  logic [2:0]               config_port_base_high;
  logic [7:0]               active_base_low;
  logic                     strap_pending;

  wire       wr_ok;
  wire       rd_ok;
  wire       wr_mode;
  wire       wr_t1;
  wire       wr_t2;
  wire       wr_t3;
  wire       wr_low;
  wire       wr_high;
  wire       rd_known;
  wire [7:0] strap_base;
  wire [7:0] next_rdata;

  // Gating by configuration state
  assign wr_ok   = access_i.wr && config_active_i;
  assign rd_ok   = access_i.rd && config_active_i;
  assign wr_mode = wr_ok && access_i.index == `IDX_UART_MODE;
  assign wr_t1   = wr_ok && access_i.index == `IDX_TEST_ONE;
  assign wr_t2   = wr_ok && access_i.index == `IDX_TEST_TWO;
  assign wr_t3   = wr_ok && access_i.index == `IDX_TEST_THREE;
  assign wr_low  = wr_ok && access_i.index == `IDX_BASE_LOW;
  assign wr_high = wr_ok && access_i.index == `IDX_BASE_HIGH;

  assign strap_base = base_address_strap_i ? `RST_BASE_LOW_STRAP1
                                           : `RST_BASE_LOW_STRAP0;

  assign rd_known = access_i.index inside {`IDX_UART_MODE, `IDX_DEVICE_ID,
                                           `IDX_REVISION, `IDX_TEST_ONE,
                                           `IDX_TEST_TWO, `IDX_TEST_THREE,
                                           `IDX_BASE_LOW, `IDX_BASE_HIGH};

  assign next_rdata =
    !rd_ok                                  ? 8'h00 :
    access_i.index == `IDX_UART_MODE        ? uart_mode_control :
    access_i.index == `IDX_DEVICE_ID        ? `DEVICE_ID_VALUE :
    access_i.index == `IDX_REVISION         ? `REVISION_VALUE :
    access_i.index == `IDX_TEST_ONE         ? test_one_o :
    access_i.index == `IDX_TEST_TWO         ? test_two_o :
    access_i.index == `IDX_TEST_THREE       ? test_three_o :
    access_i.index == `IDX_BASE_LOW         ? (config_port_base_low & `BASE_LOW_MASK) :
    access_i.index == `IDX_BASE_HIGH        ? {5'h00, config_port_base_high} :
                                              8'h00;

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      uart_mode_control <= `RST_UART_MODE;
      test_one_o        <= `RST_TEST_ONE;
      test_two_o        <= `RST_TEST_TWO;
      test_three_o      <= `RST_TEST_THREE;
    end
    else
    begin
      if (wr_mode)
        uart_mode_control <= access_i.wdata;
      if (wr_t1)
        test_one_o <= access_i.wdata;
      if (wr_t2)
        test_two_o <= access_i.wdata;
      if (wr_t3)
        test_three_o <= access_i.wdata;
    end
  end

  // Strap is sampled on the first clock after reset release, so the
  // asynchronous reset itself loads only constants.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      strap_pending         <= 1'b1;
      config_port_base_low  <= `RST_BASE_LOW_STRAP0;
      active_base_low       <= `RST_BASE_LOW_STRAP0;
      config_port_base_high <= 3'h0;
    end
    else if (strap_pending)
    begin
      strap_pending        <= 1'b0;
      config_port_base_low <= strap_base;
      active_base_low      <= strap_base;
    end
    else
    begin
      if (wr_low)
        config_port_base_low <= access_i.wdata & `BASE_LOW_MASK;
      if (wr_high)
      begin
        config_port_base_high <= access_i.wdata[2:0];
        active_base_low       <= config_port_base_low;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rdata_o  <= next_rdata;
      rvalid_o <= rd_ok && rd_known;
    end
  end

  // Decode runs off the committed base, not the staged low byte
  cfg_port_decode u_port_decode (
    .host_addr_i (host_addr_i),
    .base_low_i  (active_base_low),
    .base_high_i (config_port_base_high),
    .hit_index_o (hit_index_o),
    .hit_data_o  (hit_data_o)
  );

  uart_mode_decode u_mode_decode (
    .mode_i (uart_mode_control),
    .ctrl_o (uart_ctrl_o)
  );

endmodule // cfg_uart_regs

/* verif/cfg_uart_regs_sva.sv */
`include "cfg_regs_map.svh"

module cfg_uart_regs_sva (
  // Clock and reset
  input wire logic                      mclk_i,
  input wire logic                      nrst_i,
  // Access side
  input wire logic                      config_active_i,
  input wire cfg_regs_pkg::cfg_access_t access_i,
  input wire logic [7:0]                rdata_o,
  input wire logic                      rvalid_o,
  // Decode and controls
  input wire logic [15:0]               host_addr_i,
  input wire logic                      hit_index_o,
  input wire logic                      hit_data_o,
  input wire cfg_regs_pkg::uart_ctrl_t  uart_ctrl_o,
  input wire logic [7:0]                test_one_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0]               up_cnt;
  wire logic                rd_on = access_i.rd && config_active_i;
  wire logic                wr_on = access_i.wr && config_active_i;
  wire cfg_regs_pkg::uart_ctrl_t ctrl_exp = {rdata_o[0], rdata_o[1], rdata_o[2],
    rdata_o[5:3] == 3'h0, rdata_o[5:3] == 3'h1, rdata_o[5:3] == 3'h2,
    rdata_o[5:3] > 3'h2, rdata_o[6], rdata_o[7]};

  // The strap reload moves the decode at the first edge, so hold-off three edges
  always_ff @(posedge mclk_i or negedge nrst_i)
    if (!nrst_i)
      up_cnt <= 2'h0;
    else if (up_cnt != 2'h3)
      up_cnt <= up_cnt + 2'h1;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence rd_of(logic [7:0] idx);
    rd_on && access_i.index == idx;
  endsequence
  sequence held_hit;
    up_cnt == 2'h3 && hit_index_o && !(wr_on && access_i.index == 8'h13) ##1 $stable(host_addr_i);
  endsequence

  rd_off_a: assert property (access_i.rd && !config_active_i |=> !rvalid_o && rdata_o == 8'h00)
    else $error("read outside configuration state answered");
  rd_mode_a: assert property (rd_of(8'h0c) |=> rvalid_o)
    else $error("mode register read not answered");
  dev_id_a: assert property (rd_of(8'h0d) |=> rdata_o == `DEVICE_ID_VALUE)
    else $error("identification read wrong");
  test_wr_a: assert property (wr_on && access_i.index == 8'h0f |=> test_one_o == $past(access_i.wdata))
    else $error("test register write lost");
  hit_range_a: assert property (hit_index_o |-> host_addr_i[15:11] == 5'h00 && !host_addr_i[0])
    else $error("index hit with bad address");
  data_odd_a: assert property (hit_data_o |-> host_addr_i[15:11] == 5'h00 && host_addr_i[0])
    else $error("data hit with bad address");
  low_hold_a: assert property (held_hit |-> hit_index_o)
    else $error("decode moved without high base write");
  mode_map_a: assert property (rvalid_o && $past(access_i.index) == 8'h0c |-> uart_ctrl_o == ctrl_exp)
    else $error("serial controls disagree with mode register");
  base_mask_a: assert property (rd_of(8'h12) |=> !rdata_o[0])
    else $error("low base bit zero set");
  high_mask_a: assert property (rd_of(8'h13) |=> rdata_o[7:3] == 5'h00)
    else $error("high base reserved bits set");
endmodule // cfg_uart_regs_sva

bind cfg_uart_regs cfg_uart_regs_sva u_cfg_uart_regs_sva (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .config_active_i(config_active_i), .access_i(access_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .host_addr_i(host_addr_i), .hit_index_o(hit_index_o),
  .hit_data_o(hit_data_o), .uart_ctrl_o(uart_ctrl_o), .test_one_o(test_one_o));

/* verif/host_model.sv */
module host_model (
  // Clock and device answers
  input  wire logic                mclk_i,
  input  wire logic [7:0]          rdata_i,
  input  wire logic                rvalid_i,
  // Configuration access
  output cfg_regs_pkg::cfg_access_t access_o,
  output logic                     config_active_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    access_o = '0;
    config_active_o = 1'h1;
  end

  task automatic set_active(input logic a);
    @(negedge mclk_i);
    config_active_o = a;
  endtask

  // One access per call; an idle cycle always follows, so pulses never merge
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      output logic [7:0] q, output logic v);
    @(negedge mclk_i);
    access_o = '{wr: w, rd: !w, index: idx, wdata: d};
    @(negedge mclk_i);
    access_o = '0;
    q = rdata_i;
    v = rvalid_i;
  endtask
endmodule // host_model

/* verif/config_uart_mode_base_addr_regs_tb_top.sv */
`include "cfg_regs_map.svh"

module config_uart_mode_base_addr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      mclk, nrst, strap, active, rvalid, hit_idx, hit_dat;
  logic [15:0]               host_addr;
  logic [7:0]                rdata, t1, t2, t3;
  cfg_regs_pkg::cfg_access_t access;
  cfg_regs_pkg::uart_ctrl_t  ctrl;
  int                        n_fail = 0;
  int                        checks_done = 0;
  logic [7:0] idx_tab [8] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13};
  logic [7:0] rst_tab [8] = '{8'h02, `DEVICE_ID_VALUE, `REVISION_VALUE, 8'h00, 8'h00,
                              8'h80, 8'h4e, 8'h00};

  cfg_uart_regs u_cfg_uart_regs (.mclk_i(mclk), .nrst_i(nrst), .base_address_strap_i(strap),
    .config_active_i(active), .access_i(access), .rdata_o(rdata), .rvalid_o(rvalid),
    .host_addr_i(host_addr), .hit_index_o(hit_idx), .hit_data_o(hit_dat), .uart_ctrl_o(ctrl),
    .test_one_o(t1), .test_two_o(t2), .test_three_o(t3));
  host_model u_host_model (.mclk_i(mclk), .rdata_i(rdata), .rvalid_i(rvalid),
    .access_o(access), .config_active_o(active));

  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  task automatic report_and_stop;
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic s);
    // A mid-run reset starts on a falling edge like every other input
    if (nrst === 1'h1)
      @(negedge mclk);
    nrst = 1'h0;
    strap = s;
    repeat (8) @(negedge mclk);
    nrst = 1'h1;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    logic       v;
    u_host_model.xfer(1'h1, idx, d, q, v);
  endtask

  // Expected value carries the valid flag in bit 8
  task automatic rd(input logic [7:0] idx, input logic [8:0] e);
    logic [7:0] q;
    logic       v;
    u_host_model.xfer(1'h0, idx, 8'h00, q, v);
    chk({7'h00, v, q}, {7'h00, e});
  endtask

  task automatic hit(input logic [15:0] a, input logic ei, input logic ed);
    @(negedge mclk);
    host_addr = a;
    #1 chk({14'h0000, hit_idx, hit_dat}, {14'h0000, ei, ed});
  endtask

  // Whole sequence needs about 106 cycles; the 3000-cycle limit is some 28 times that
  initial
  begin
    #30000;
    n_fail++;
    report_and_stop;
  end

  initial
  begin
    logic [7:0] d;
    logic [8:0] e;
    host_addr = 16'h0000;
    do_reset(1'h0);
    hit(16'h002e, 1'h1, 1'h0);
    hit(16'h002f, 1'h0, 1'h1);
    do_reset(1'h1);
    hit(16'h004e, 1'h1, 1'h0);
    for (int k = 0; k < 8; k++)
      rd(idx_tab[k], {1'h1, rst_tab[k]});
    chk({7'h00, ctrl}, 16'h00a0);
    for (int m = 0; m < 8; m++)
    begin
      d = {m[0], ~m[0], m[2:0], m[1], ~m[1], m[2]};
      wr(8'h0c, d);
      rd(8'h0c, {1'h1, d});
      e = {d[0], d[1], d[2], m == 0, m == 1, m == 2, m > 2, d[6], d[7]};
      chk({7'h00, ctrl}, {7'h00, e});
    end
    wr(8'h0f, 8'h5a);
    wr(8'h10, 8'ha5);
    wr(8'h11, 8'h3c);
    chk({t1, t2}, 16'h5aa5);
    chk({8'h00, t3}, 16'h003c);
    wr(8'h0d, 8'h00);
    rd(8'h0d, {1'h1, `DEVICE_ID_VALUE});
    wr(8'h0e, 8'hff);
    rd(8'h0e, {1'h1, `REVISION_VALUE});
    hit(16'h004e, 1'h1, 1'h0);
    wr(8'h12, 8'h61);
    hit(16'h004e, 1'h1, 1'h0);
    rd(8'h12, 9'h160);
    wr(8'h13, 8'hf9);
    rd(8'h13, 9'h101);
    hit(16'h0160, 1'h1, 1'h0);
    hit(16'h0161, 1'h0, 1'h1);
    hit(16'h004e, 1'h0, 1'h0);
    hit(16'h0960, 1'h0, 1'h0);
    u_host_model.set_active(1'h0);
    wr(8'h0f, 8'hff);
    rd(8'h0f, 9'h000);
    u_host_model.set_active(1'h1);
    rd(8'h0f, 9'h15a);
    rd(8'h20, 9'h000);
    report_and_stop;
  end
endmodule // config_uart_mode_base_addr_regs_tb_top
